/* File: core/charger_defs.svh */
// Offsets, reset values and timing figures of the charger controller
`ifndef CHARGER_DEFS_SVH
`define CHARGER_DEFS_SVH
`define CLK_PERIOD_NS 8
`define CLK_KHZ 125000
`define REG_CTRL 4'h0
`define REG_TIMER 4'h4
`define REG_DUTY 4'h8
`define REG_STATUS 4'hC
`define CTRL_EN_BIT 0
`define CTRL_CODE_LSB 8
`define CTRL_RESET 32'h0000_8001
`define TIMER_RESET 8'h5A
`define DUTY_RESET 7'h00
`define T_TICK_US 100
`define TICK_CYCLES_DEF (`T_TICK_US * 1000 / `CLK_PERIOD_NS)
`define T_PRECHG_MIN 30
`define PRECHG_TICKS_DEF (`T_PRECHG_MIN * 60 * 1000 * 1000 / `T_TICK_US)
`define MIN_TICKS_DEF (60 * 1000 * 1000 / `T_TICK_US)
`define T_CE_DELAY_MS 1500
`define CE_TICKS_DEF (`T_CE_DELAY_MS * 1000 / `T_TICK_US)
`define T_DEGLITCH_MS 25
`define DEGLITCH_TICKS (`T_DEGLITCH_MS * 1000 / `T_TICK_US)
`define T_SS_STEP_US 1600
`define SS_STEP_TICKS (`T_SS_STEP_US / `T_TICK_US)
`define SS_STEPS 4'h8
`define PRECHG_DIV 10
`define T_BREAK_NS 10000
`define BREAK_CYCLES ((`T_BREAK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PWM_FREQ_KHZ 1600
`define PWM_PERIOD (`CLK_KHZ / `PWM_FREQ_KHZ)
`define DUTY_MAX_PCT 97
`define PWM_ON_MAX (`PWM_PERIOD * `DUTY_MAX_PCT / 100)
`endif

/* File: core/charger_pkg.sv */
// Types shared by the charger controller
package charger_pkg;
  typedef enum logic [2:0] {
    CHG_IDLE, CHG_PRE, CHG_FAST, CHG_DONE, CHG_FAULT
  } chg_state_t;
  typedef enum logic [1:0] {PP_BAT, PP_BREAK, PP_AC, PP_REMOVE} pp_state_t;
  typedef struct packed {
    logic lockout;            // Supply below undervoltage lockout
    logic supply_gt_sense;    // Supply above battery sense node
    logic sense_gt_supply;    // Battery sense node above supply
    logic supply_gt_sense_300; // Supply above sense node plus 300 mV
    logic insense_lt_sense_200; // Input sense below sense node plus 200 mV
    logic sys_near_sense;     // System node close to battery sense node
    logic qual_high;          // Adapter qualify input above 1.6 V
    logic qual_low;           // Adapter qualify input below 0.5 V
    logic bat_low;            // Battery below low threshold
    logic bat_below_rechg;    // Battery below recharge threshold
    logic cset_above_120;     // Charge current set input above 120 mV
    logic cset_below_40;      // Charge current set input below 40 mV
    logic ldo_ok;             // Both regulators in range
    logic thermal_shutdown;   // Die over temperature
    logic temp_fault;         // Battery temperature out of range
    logic ichg_below_term;    // Charge current below termination level
    logic volt_reg;           // Voltage regulation phase active
    logic tcap_gnd;           // Timer capacitor pin tied to ground
    logic tcap_ref;           // Timer capacitor pin tied to reference
  } sense_flags_t;
  typedef struct packed {
    logic charging;
    logic done;
  } stat_t;
endpackage : charger_pkg

/* File: core/charger_ctrl.sv */
// Charger sequencing, safety timers, power-path selector and register slave
// Contract
// RQ1: Low battery at power-up starts precharge
// RQ2: Precharge over 30 minutes turns charger off, fault
// RQ3: Precharge setpoint is tenth of fast setpoint
// RQ4: Terminate in regulation above recharge, low current
// RQ5: Phase changes need 25 ms persistence
// RQ6: Timer pin ground kills termination and timer
// RQ7: Recharge, power-on or set-input toggle restarts cycle
// RQ8: Sleep follows supply versus sense comparison
// RQ9: Sleep turns reference off, status high impedance
// RQ10: Lockout disables everything
// RQ11: Qualify input outside window stops charge, switches
// RQ12: Charge only when every qualification holds
// RQ13: Any listed fault stops ongoing charge
// RQ14: Battery switch on at power-up and sleep
// RQ15: Changeover needs 300 mV, 10 us both off
// RQ16: Adapter switch on only when qualified, 300 mV
// RQ17: Battery switch on when supplied, input near battery
// RQ18: Removal: adapter off, battery on when system low
// RQ19: Fixed 1.6 MHz switching, at most 97 % on
// RQ20: Fast charge ramps setpoint in eight steps
// RQ21: Flags synchronous; timers from divided clock (the break counter and the gate drive counter count clock cycles)
// RQ22: Lockout returns state machine idle, clears timers
//
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "charger_defs.svh"
module charger_ctrl #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES_DEF,
  parameter int unsigned PRECHG_TICKS = `PRECHG_TICKS_DEF,
  parameter int unsigned MIN_TICKS = `MIN_TICKS_DEF,
  parameter int unsigned CE_TICKS = `CE_TICKS_DEF
) (
  input wire logic clk_in, // 125 MHz clock
  input wire logic reset_in, // Synchronous reset, active high
  input wire charger_pkg::sense_flags_t flags_in, // Comparator flags
  input wire logic [3:0] avs_address_in, // Byte address
  input wire logic avs_read_in, // Read request
  input wire logic avs_write_in, // Write request
  input wire logic [3:0] avs_byteenable_in, // Byte lanes
  input wire logic [31:0] avs_writedata_in, // Write data
  output logic [31:0] avs_readdata_out, // Read data
  output logic avs_waitrequest_out, // Stall, low marks the answer
  output logic [7:0] setpoint_out, // Charge current setpoint code
  output logic pwm_out, // High-side gate drive
  output logic adapter_switch_out, // Adapter switch gate on
  output logic battery_switch_out, // Battery switch gate on
  output charger_pkg::stat_t stat_out, // Status pin levels
  output logic stat_oe_n_out, // Status pins driven when low
  output logic vref_en_out // Reference output enable
);
  import charger_pkg::*;
  function automatic logic [7:0] pre_set(input logic [7:0] code);
    pre_set = code / 8'(`PRECHG_DIV);
  endfunction : pre_set

  function automatic logic [7:0] ramp_set(input logic [7:0] code,
                                          input logic [3:0] step);
    logic [11:0] prod;
    prod = 12'(code) * 12'(step);
    ramp_set = prod[10:3];
  endfunction : ramp_set

  sense_flags_t f;
  chg_state_t state_q, last_q;
  pp_state_t pp_q;
  logic [31:0] ctrl_q, tick_cnt_q, ce_cnt_q, phase_cnt_q, fast_lim;
  logic [7:0] timer_min_q;
  logic [6:0] duty_q, pwm_cnt_q, on_lim;
  logic [15:0] dg_cnt_q;
  logic [10:0] brk_cnt_q;
  logic [7:0] ss_cnt_q;
  logic [3:0] ss_step_q;
  logic tick_q, ce_done_q, sleep_q, wait_q, seen_low_q;
  logic qualified, charge_ok, stop, entering, dg_done, restart;
  logic pre_expire, fast_expire, term;

  assign f = flags_in; // RQ21
  assign qualified = !f.qual_high && !f.qual_low;
  assign entering = state_q != last_q;
  assign fast_lim = 32'(timer_min_q) * MIN_TICKS;
  assign dg_done = dg_cnt_q == 16'(`DEGLITCH_TICKS) && !entering;
  assign pre_expire = phase_cnt_q >= PRECHG_TICKS;
  assign fast_expire = !f.tcap_gnd && !f.tcap_ref && // RQ6
                       phase_cnt_q >= fast_lim;
  assign term = f.volt_reg && !f.bat_below_rechg && // RQ4
                f.ichg_below_term && !f.tcap_gnd; // RQ6
  assign charge_ok = f.cset_above_120 && !f.lockout && !sleep_q && // RQ12
                     qualified && ce_done_q && f.ldo_ok &&
                     !f.thermal_shutdown && !f.temp_fault &&
                     adapter_switch_out && ctrl_q[`CTRL_EN_BIT];
  assign stop = f.cset_below_40 || f.lockout || sleep_q || // RQ13
                !qualified || !f.ldo_ok || f.thermal_shutdown ||
                f.temp_fault || !adapter_switch_out ||
                !ctrl_q[`CTRL_EN_BIT];
  assign restart = seen_low_q && f.cset_above_120; // RQ7
  assign on_lim = (duty_q > 7'(`PWM_ON_MAX)) ? 7'(`PWM_ON_MAX) : duty_q;

  // Timebase tick shared by every timer except the changeover break counter and the gate drive counter, which count clock cycles
  always_ff @(posedge clk_in) begin // RQ21
    if (reset_in || tick_cnt_q >= TICK_CYCLES - 1) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
    tick_q <= !reset_in && tick_cnt_q >= TICK_CYCLES - 1;
  end

  // Power-up delay runs once per lockout release
  always_ff @(posedge clk_in) begin
    if (reset_in || f.lockout) begin // RQ10
      ce_cnt_q <= 32'h0000_0000;
      ce_done_q <= 1'b0;
    end else if (tick_q && !ce_done_q) begin
      ce_cnt_q <= ce_cnt_q + 32'h0000_0001;
      ce_done_q <= ce_cnt_q + 32'h0000_0001 >= CE_TICKS;
    end
  end

  // Comparator has no dead band; both flags low keeps the last mode
  always_ff @(posedge clk_in) begin
    if (reset_in || f.lockout) begin
      sleep_q <= 1'b1;
    end else if (f.sense_gt_supply) begin // RQ8
      sleep_q <= 1'b1;
    end else if (f.supply_gt_sense) begin // RQ8
      sleep_q <= 1'b0;
    end
  end

  // Set input must dip below 40 mV before a rise re-arms a cycle
  always_ff @(posedge clk_in) begin
    if (reset_in || f.cset_above_120) begin
      seen_low_q <= 1'b0;
    end else if (f.cset_below_40) begin
      seen_low_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in || f.lockout) begin
      state_q <= CHG_IDLE; // RQ22
    end else begin
      unique case (state_q)
        CHG_IDLE: if (charge_ok) begin
          state_q <= f.bat_low ? CHG_PRE : CHG_FAST; // RQ1
        end
        CHG_PRE: begin
          if (stop) begin
            state_q <= CHG_IDLE; // RQ13
          end else if (pre_expire) begin
            state_q <= CHG_FAULT; // RQ2
          end else if (dg_done) begin
            state_q <= CHG_FAST; // RQ5
          end
        end
        CHG_FAST: begin
          if (stop) begin
            state_q <= CHG_IDLE; // RQ13
          end else if (fast_expire) begin
            state_q <= CHG_FAULT;
          end else if (dg_done) begin
            state_q <= CHG_PRE; // RQ5
          end else if (term) begin
            state_q <= CHG_DONE; // RQ4
          end
        end
        CHG_DONE: if (f.bat_below_rechg || restart) begin
          state_q <= CHG_IDLE; // RQ7
        end
        CHG_FAULT: if (restart) begin
          state_q <= CHG_IDLE; // RQ7
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    last_q <= reset_in ? CHG_IDLE : state_q;
  end

  // Phase timer; a ground-tied timer pin holds it cleared in fast charge
  always_ff @(posedge clk_in) begin
    if (reset_in || f.lockout || entering || // RQ22
        (state_q != CHG_PRE && state_q != CHG_FAST) ||
        (state_q == CHG_FAST && f.tcap_gnd)) begin // RQ6
      phase_cnt_q <= 32'h0000_0000;
    end else if (tick_q) begin
      phase_cnt_q <= phase_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in || f.lockout || entering ||
        !((state_q == CHG_PRE && !f.bat_low) ||
          (state_q == CHG_FAST && f.bat_low))) begin
      dg_cnt_q <= 16'h0000;
    end else if (tick_q && !dg_done) begin // RQ5
      dg_cnt_q <= dg_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in || state_q != CHG_FAST || entering) begin
      ss_step_q <= 4'h1; // RQ20
      ss_cnt_q <= 8'h00;
    end else if (tick_q && ss_step_q != `SS_STEPS) begin
      if (ss_cnt_q == 8'(`SS_STEP_TICKS - 1)) begin
        ss_cnt_q <= 8'h00;
        ss_step_q <= ss_step_q + 4'h1; // RQ20
      end else begin
        ss_cnt_q <= ss_cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      setpoint_out <= 8'h00;
    end else if (state_q == CHG_PRE) begin
      setpoint_out <= pre_set(ctrl_q[`CTRL_CODE_LSB +: 8]); // RQ3
    end else if (state_q == CHG_FAST) begin
      setpoint_out <= ramp_set(ctrl_q[`CTRL_CODE_LSB +: 8], ss_step_q);
    end else begin
      setpoint_out <= 8'h00;
    end
  end

  // Fixed-period gate drive; on-time capped, duty words beyond the cap are clamped to it
  always_ff @(posedge clk_in) begin
    if (reset_in || pwm_cnt_q == 7'(`PWM_PERIOD - 1)) begin // RQ19
      pwm_cnt_q <= 7'h00;
    end else begin
      pwm_cnt_q <= pwm_cnt_q + 7'h01;
    end
    pwm_out <= !reset_in && (state_q == CHG_PRE || state_q == CHG_FAST) &&
               pwm_cnt_q < on_lim; // RQ19
  end

  always_ff @(posedge clk_in) begin
    if (reset_in || f.lockout) begin
      pp_q <= PP_BAT;
      brk_cnt_q <= 11'h000;
    end else begin
      unique case (pp_q)
        PP_BAT: if (!sleep_q && f.supply_gt_sense_300 && qualified) begin
          pp_q <= PP_BREAK; // RQ15
          brk_cnt_q <= 11'h000;
        end
        PP_BREAK: begin
          if (!qualified || !f.supply_gt_sense_300 || sleep_q) begin
            pp_q <= PP_REMOVE;
          end else if (brk_cnt_q == 11'(`BREAK_CYCLES - 1)) begin
            pp_q <= PP_AC; // RQ15
          end else begin
            brk_cnt_q <= brk_cnt_q + 11'h001;
          end
        end
        PP_AC: if (!qualified || !f.supply_gt_sense_300 || sleep_q) begin
          pp_q <= PP_REMOVE; // RQ11 RQ16 RQ18
        end
        PP_REMOVE: if (f.sys_near_sense) begin
          pp_q <= PP_BAT; // RQ18
        end
      endcase
    end
  end

  // Switch gates lag the selector by one cycle; both are off in BREAK
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      adapter_switch_out <= 1'b0;
      battery_switch_out <= 1'b0;
    end else begin
      adapter_switch_out <= pp_q == PP_AC && qualified && // RQ16
                            f.supply_gt_sense_300 && !f.lockout;
      battery_switch_out <= pp_q == PP_BAT && !f.lockout && // RQ14 RQ17
                            f.insense_lt_sense_200;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      stat_out <= '0;
      stat_oe_n_out <= 1'b1;
      vref_en_out <= 1'b0;
    end else begin
      stat_out.charging <= state_q == CHG_PRE || state_q == CHG_FAST ||
                           state_q == CHG_FAULT;
      stat_out.done <= state_q == CHG_DONE || state_q == CHG_FAULT; // RQ2
      stat_oe_n_out <= sleep_q || f.lockout; // RQ9
      vref_en_out <= !sleep_q && !f.lockout; // RQ9
    end
  end

  // Register slave: one wait cycle, answer on the second edge
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) &&
                               avs_waitrequest_out);
      if (avs_read_in && avs_waitrequest_out) begin
        unique case (avs_address_in)
          `REG_CTRL: avs_readdata_out <= ctrl_q;
          `REG_TIMER: avs_readdata_out <= {24'h00_0000, timer_min_q};
          `REG_DUTY: avs_readdata_out <= {25'h000_0000, duty_q};
          `REG_STATUS: avs_readdata_out <= {8'h00, setpoint_out,
              5'h00, battery_switch_out, adapter_switch_out, sleep_q,
              1'b0, pp_q, 2'h0, state_q};
          default: avs_readdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_q <= `CTRL_RESET;
      timer_min_q <= `TIMER_RESET;
      duty_q <= `DUTY_RESET;
    end else if (avs_write_in && !avs_waitrequest_out) begin
      if (avs_address_in == `REG_CTRL) begin
        for (int b = 0; b < 2; b++) begin
          if (avs_byteenable_in[b]) begin
            ctrl_q[8*b +: 8] <= avs_writedata_in[8*b +: 8];
          end
        end
      end
      if (avs_address_in == `REG_TIMER && avs_byteenable_in[0]) begin
        timer_min_q <= avs_writedata_in[7:0];
      end
      if (avs_address_in == `REG_DUTY && avs_byteenable_in[0]) begin
        duty_q <= avs_writedata_in[6:0];
      end
    end
  end

  property p_lockout_idle;
    @(posedge clk_in) disable iff (reset_in)
      f.lockout |=> state_q == CHG_IDLE && phase_cnt_q == 32'h0000_0000;
  endproperty
  a_lockout_idle: assert property (p_lockout_idle) // RQ22
    else $error("lockout did not idle the charger");
  property p_pre_level;
    @(posedge clk_in) disable iff (reset_in)
      state_q == CHG_PRE && $past(state_q) == CHG_PRE |=>
        setpoint_out == $past(ctrl_q[`CTRL_CODE_LSB +: 8]) / 8'(`PRECHG_DIV);
  endproperty
  a_pre_level: assert property (p_pre_level) // RQ3
    else $error("precharge setpoint wrong");
  property p_break;
    @(posedge clk_in) disable iff (reset_in)
      $rose(adapter_switch_out) |->
        $past(pp_q, 2) == PP_BREAK && !battery_switch_out;
  endproperty
  a_break: assert property (p_break) // RQ15
    else $error("adapter switch on without break");
  property p_ac_qual;
    @(posedge clk_in) disable iff (reset_in)
      (f.qual_high || f.qual_low) |=> !adapter_switch_out;
  endproperty
  a_ac_qual: assert property (p_ac_qual) // RQ11
    else $error("adapter switch on outside window");
  property p_sleep_pins;
    @(posedge clk_in) disable iff (reset_in)
      sleep_q |=> stat_oe_n_out && !vref_en_out;
  endproperty
  a_sleep_pins: assert property (p_sleep_pins) // RQ9
    else $error("sleep pins wrong");
  property p_pwm_cap;
    @(posedge clk_in) disable iff (reset_in)
      pwm_cnt_q >= 7'(`PWM_ON_MAX) |=> !pwm_out;
  endproperty
  a_pwm_cap: assert property (p_pwm_cap) // RQ19
    else $error("duty above limit");
  property p_stop;
    @(posedge clk_in) disable iff (reset_in)
      (state_q == CHG_PRE || state_q == CHG_FAST) && stop |=>
        state_q == CHG_IDLE;
  endproperty
  a_stop: assert property (p_stop) // RQ13
    else $error("charge not stopped");
  property p_pre_timeout;
    @(posedge clk_in) disable iff (reset_in)
      state_q == CHG_PRE && !stop && pre_expire |=>
        state_q == CHG_FAULT ##1 stat_out.done;
  endproperty
  a_pre_timeout: assert property (p_pre_timeout) // RQ2
    else $error("precharge timeout missed");
  property p_tcap_gnd;
    @(posedge clk_in) disable iff (reset_in)
      state_q == CHG_FAST && f.tcap_gnd |=>
        phase_cnt_q == 32'h0000_0000 && state_q != CHG_DONE;
  endproperty
  a_tcap_gnd: assert property (p_tcap_gnd) // RQ6
    else $error("timer not held by grounded pin");
endmodule : charger_ctrl

/* File: verification/charger_partner.sv */
// Adapter and battery pack seen as comparator flags at the controller
`timescale 1ns/100ps
module charger_partner (
  input wire logic clk_in, // Bench clock
  input wire logic reset_in, // Bench reset, active high
  input wire logic adapter_in, // Adapter plugged and above battery
  input wire charger_pkg::sense_flags_t base_in, // Levels set by the bench
  input wire logic adapter_switch_in, // Adapter switch gate from the device
  output charger_pkg::sense_flags_t flags_out // Flags to the device
);
  import charger_pkg::*;
  logic [4:0] decay_q;

  // System node decays slowly once nothing feeds it
  // Out of reset the battery alone feeds the system
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      decay_q <= 5'h1f;
    end else if (adapter_switch_in || adapter_in) begin
      decay_q <= 5'h00;
    end else if (decay_q != 5'h1f) begin
      decay_q <= decay_q + 5'h01;
    end
  end

  always_comb begin
    flags_out = base_in;
    flags_out.supply_gt_sense = adapter_in;
    flags_out.sense_gt_supply = !adapter_in;
    flags_out.supply_gt_sense_300 = adapter_in;
    flags_out.sys_near_sense = (decay_q == 5'h1f);
    flags_out.insense_lt_sense_200 = (decay_q == 5'h1f);
  end
endmodule : charger_partner

/* File: verification/charger_ctrl_tb.sv */
// Self-checking bench for the charger controller
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); \
  end \
end
module charger_ctrl_tb;
  import charger_pkg::*;
  logic clk_in, reset_in, avs_read_in, avs_write_in, adapter, bad;
  logic [3:0] avs_address_in, avs_byteenable_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, rd;
  logic avs_waitrequest_out, pwm_out, adapter_switch_out, battery_switch_out;
  logic stat_oe_n_out, vref_en_out;
  logic [7:0] setpoint_out, code, tmr;
  logic [6:0] duty;
  stat_t stat_out;
  sense_flags_t base, flags;
  int mismatches, num_checks, n, hi;

  charger_partner u_partner (.clk_in(clk_in), .reset_in(reset_in),
    .adapter_in(adapter),
    .base_in(base), .adapter_switch_in(adapter_switch_out), .flags_out(flags));
  charger_ctrl #(.TICK_CYCLES(4), .PRECHG_TICKS(400), .MIN_TICKS(10),
    .CE_TICKS(5)) u_dut (.clk_in(clk_in), .reset_in(reset_in),
    .flags_in(flags), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .setpoint_out(setpoint_out),
    .pwm_out(pwm_out), .adapter_switch_out(adapter_switch_out),
    .battery_switch_out(battery_switch_out), .stat_out(stat_out),
    .stat_oe_n_out(stat_oe_n_out), .vref_en_out(vref_en_out));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic conclude();
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // On-cycles per period: 1.6 MHz period at 125 MHz, capped at 97 %
  function automatic int on_exp(input int d);
    int lim;
    lim = (125000 / 1600) * 97 / 100;
    return (d > lim) ? lim : d;
  endfunction : on_exp

  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    avs_address_in <= a;
    avs_read_in <= !w;
    avs_write_in <= w;
    avs_writedata_in <= d;
    do begin
      @(posedge clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask : bus

  // Polls the status register, bounded by lim reads
  task automatic wait_st(input logic [2:0] s, input int lim);
    n = 0;
    do begin
      bus(1'b0, 4'hC, 32'h0000_0000);
      n++;
    end while (rd[2:0] !== s && n < lim);
  endtask : wait_st

  task automatic cyc(input int c);
    repeat (c) @(posedge clk_in);
  endtask : cyc

  initial begin
    #(60000 * 8);
    mismatches++;
    conclude();
  end

  initial begin
    reset_in = 1'b1;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_address_in = 4'h0;
    avs_byteenable_in = 4'hf;
    avs_writedata_in = 32'h0000_0000;
    adapter = 1'b0;
    base = '0;
    base.ldo_ok = 1'b1;
    base.cset_above_120 = 1'b1;
    base.bat_low = 1'b1;
    mismatches = 0;
    num_checks = 0;
    void'($urandom(32'h21bf));
    code = 8'($urandom_range(255, 20));
    tmr = 8'($urandom_range(255, 120));
    cyc(4);
    reset_in <= 1'b0;
    cyc(50);
    `CHK("bat_sw", 1'b1, battery_switch_out)
    `CHK("ac_sw", 1'b0, adapter_switch_out)
    `CHK("vref_en", 1'b0, vref_en_out)
    `CHK("stat_oe_n", 1'b1, stat_oe_n_out)
    bus(1'b0, 4'h0, 32'h0000_0000);
    `CHK("ctrl_rst", 32'h0000_8001, rd)
    bus(1'b0, 4'h4, 32'h0000_0000);
    `CHK("timer_rst", 32'h0000_005A, rd)
    bus(1'b0, 4'h8, 32'h0000_0000);
    `CHK("duty_rst", 32'h0000_0000, rd)
    bus(1'b0, 4'h2, 32'h0000_0000);
    `CHK("unmapped", 32'h0000_0000, rd)
    bus(1'b1, 4'h4, {24'h0000_00, tmr});
    bus(1'b0, 4'h4, 32'h0000_0000);
    `CHK("timer_wr", {24'h0000_00, tmr}, rd)
    bus(1'b1, 4'h0, {16'h0000, code, 8'h01});
    // Adapter arrives: break-before-make changeover
    adapter <= 1'b1;
    n = 0;
    while (battery_switch_out !== 1'b0 && n < 100) begin
      cyc(1);
      n++;
    end
    n = 0;
    bad = 1'b0;
    while (adapter_switch_out !== 1'b1 && n < 2000) begin
      cyc(1);
      n++;
      if (battery_switch_out !== 1'b0) bad = 1'b1;
    end
    `CHK("break_len", 1'b1, (n >= 1249 && n <= 1252))
    `CHK("break_bat", 1'b0, bad)
    `CHK("vref_on", 1'b1, vref_en_out)
    `CHK("stat_oe", 1'b0, stat_oe_n_out)
    // Low battery goes to precharge at a tenth
    wait_st(3'd1, 200);
    `CHK("pre_state", 3'd1, rd[2:0])
    cyc(2);
    `CHK("pre_sp", code / 8'd10, setpoint_out)
    `CHK("pre_stat", 2'b10, stat_out)
    wait_st(3'd4, 700);
    `CHK("pre_tmo", 3'd4, rd[2:0])
    cyc(2);
    `CHK("fault_stat", 2'b11, stat_out)
    `CHK("fault_sp", 8'h00, setpoint_out)
    // Set input toggle restarts, then deglitched move to fast
    base.cset_above_120 <= 1'b0;
    base.cset_below_40 <= 1'b1;
    cyc(10);
    base.cset_above_120 <= 1'b1;
    base.cset_below_40 <= 1'b0;
    wait_st(3'd1, 100);
    `CHK("restart", 3'd1, rd[2:0])
    base.bat_low <= 1'b0;
    cyc(900);
    bus(1'b0, 4'hC, 32'h0000_0000);
    `CHK("deglitch", 3'd1, rd[2:0])
    wait_st(3'd2, 100);
    `CHK("fast", 3'd2, rd[2:0])
    cyc(4);
    `CHK("ramp1", code >> 3, setpoint_out)
    cyc(600);
    `CHK("ramp8", code, setpoint_out)
    // Gate drive on-time follows the duty word up to the cap
    duty = 7'($urandom_range(127, 60));
    bus(1'b1, 4'h8, {25'h000_0000, duty});
    bus(1'b0, 4'h8, 32'h0000_0000);
    `CHK("duty_wr", {25'h000_0000, duty}, rd)
    cyc(2);
    hi = 0;
    repeat (78) begin
      cyc(1);
      if (pwm_out === 1'b1) hi++;
    end
    `CHK("pwm_on", on_exp(duty), hi)
    // Grounded timer pin blocks termination
    base.tcap_gnd <= 1'b1;
    base.volt_reg <= 1'b1;
    base.ichg_below_term <= 1'b1;
    cyc(100);
    bus(1'b0, 4'hC, 32'h0000_0000);
    `CHK("no_term", 3'd2, rd[2:0])
    base.tcap_gnd <= 1'b0;
    wait_st(3'd3, 30);
    `CHK("term", 3'd3, rd[2:0])
    `CHK("done_stat", 2'b01, stat_out)
    base.bat_below_rechg <= 1'b1;
    base.volt_reg <= 1'b0;
    wait_st(3'd2, 100);
    `CHK("recharge", 3'd2, rd[2:0])
    base.bat_below_rechg <= 1'b0;
    // Each fault stops charge; clearing it lets charge resume
    for (int i = 0; i < 3; i++) begin
      base.thermal_shutdown <= (i == 0);
      base.temp_fault <= (i == 1);
      base.ldo_ok <= (i != 2);
      wait_st(3'd0, 30);
      `CHK("stop", 3'd0, rd[2:0])
      cyc(2);
      `CHK("stop_sp", 8'h00, setpoint_out)
      base.thermal_shutdown <= 1'b0;
      base.temp_fault <= 1'b0;
      base.ldo_ok <= 1'b1;
      wait_st(3'd2, 30);
      `CHK("resume", 3'd2, rd[2:0])
    end
    // Reference-tied timer pin holds off the fast timer expiry until released
    base.tcap_ref <= 1'b1;
    cyc(tmr * 40 + 40);
    bus(1'b0, 4'hC, 32'h0000_0000);
    `CHK("ref_hold", 3'd2, rd[2:0])
    base.tcap_ref <= 1'b0;
    wait_st(3'd4, 10);
    `CHK("fast_tmo", 3'd4, rd[2:0])
    base.cset_above_120 <= 1'b0;
    base.cset_below_40 <= 1'b1;
    cyc(10);
    base.cset_above_120 <= 1'b1;
    base.cset_below_40 <= 1'b0;
    wait_st(3'd2, 100);
    `CHK("restart2", 3'd2, rd[2:0])
    base.qual_high <= 1'b1;
    cyc(4);
    `CHK("qual_sw", 1'b0, adapter_switch_out)
    wait_st(3'd0, 30);
    `CHK("qual_stop", 3'd0, rd[2:0])
    base.qual_high <= 1'b0;
    adapter <= 1'b0;
    cyc(60);
    `CHK("remove_bat", 1'b1, battery_switch_out)
    `CHK("remove_ac", 1'b0, adapter_switch_out)
    base.lockout <= 1'b1;
    cyc(4);
    bus(1'b0, 4'hC, 32'h0000_0000);
    `CHK("lockout", 3'd0, rd[2:0])
    `CHK("lock_oe", 1'b1, stat_oe_n_out)
    conclude();
  end
endmodule : charger_ctrl_tb
